// >>> rtl/taskfile_cb_pkg.sv
/*
  constants shared by the taskfile command block decoder: apb offsets,
  field positions, reset values, step counts and sequencer states.
  assumes a 32-bit apb bus with word aligned registers.
*/
package taskfile_cb_pkg;

  // apb byte offsets
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_CMD_BLK  = 8'h04;
  localparam logic [7:0] OFF_WDATA0   = 8'h08;
  localparam logic [7:0] OFF_WDATA1   = 8'h0C;
  localparam logic [7:0] OFF_WDATA2   = 8'h10;
  localparam logic [7:0] OFF_STATUS   = 8'h14;
  localparam logic [7:0] OFF_BLKSIZE  = 8'h18;
  localparam logic [7:0] OFF_READBACK = 8'h20;

  // command block word fields
  localparam int MASK_LSB      = 0;
  localparam int ACT1_LSB      = 8;
  localparam int ACT2_LSB      = 16;
  localparam int DEVHEAD_LSB   = 24;
  localparam int DEV_AFTER_BIT = 1;
  localparam int READBACK_BIT  = 0;
  localparam int HOB_WRITE_BIT = 0;
  localparam int BLK_CODE_LSB  = 4;

  // status bits
  localparam int ST_BUSY   = 0;
  localparam int ST_DONE   = 1;
  localparam int ST_FAILED = 2;

  localparam logic [31:0] CMD_BLK_RESET = 32'h0000_0000;
  localparam logic [31:0] WDATA_RESET   = 32'h0000_0000;

  // sequencing
  localparam logic [3:0] BLK_CODE_MAX   = 4'h8;
  localparam int         NUM_STEPS      = 12;
  localparam int         READBACK_BYTES = 12;
  localparam int         RB_WORDS       = 3;
  localparam logic [2:0] REG_ALT_STATUS = 3'h0;
  localparam logic [2:0] REG_DEV_HEAD   = 3'h6;
  localparam logic [2:0] REG_COMMAND    = 3'h7;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'b000_0001,
    ST_CHECK   = 7'b000_0010,
    ST_PRESEL  = 7'b000_0100,
    ST_REGS    = 7'b000_1000,
    ST_POSTSEL = 7'b001_0000,
    ST_XFER    = 7'b010_0000,
    ST_FINISH  = 7'b100_0000
  } seq_state_t;

endpackage

// >>> rtl/readback_buffer.sv
/*
  small byte-writable memory that holds the taskfile readback bytes.
  assumes one write and one read per cycle; read data is registered.
*/
`timescale 1ns/1ps
module readback_buffer #(
  parameter int LANES = 4,
  parameter int DEPTH = 3,
  parameter int AW    = 2
) (
  input  wire logic               clk,
  input  wire logic               rstN,
  input  wire logic               ce,
  input  wire logic               wrEn,
  input  wire logic [AW-1:0]      wrAddr,
  input  wire logic [1:0]         wrLane,
  input  wire logic [7:0]         wrData,
  input  wire logic [AW-1:0]      rdAddr,
  output logic      [LANES*8-1:0] rdData
);

  logic [LANES*8-1:0] mem [DEPTH];

  // one write port per byte lane
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    always_ff @(posedge clk) begin
      if (ce && wrEn && wrLane == 2'(l)) begin
        mem[wrAddr][l*8 +: 8] <= wrData;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      rdData <= '0;
    end else if (ce) begin
      rdData <= mem[rdAddr];
    end
  end

endmodule

// >>> rtl/taskfile_command_block_decode.sv
/*
  taskfile command block decoder: apb registers hold the command block,
  a sequencer performs the taskfile accesses on the ata register port,
  runs the data phase or collects the 12-byte readback.
  assumes ata port and data phase handshakes are on ref_clk.
*/
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module taskfile_command_block_decode
  import taskfile_cb_pkg::*;
#(
  parameter int BLK_W = 9
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  output logic                   ataReq,
  output logic                   ataWrite,
  output logic      [2:0]        ataReg,
  output logic                   ataHob,
  output logic      [7:0]        ataWdata,
  input  wire logic              ataAck,
  input  wire logic [7:0]        ataRdata,
  output logic                   dataStart,
  input  wire logic              dataDone,
  output logic      [BLK_W-1:0]  blockSectors
);

  logic rstMeta_q;
  logic rstSync_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  seq_state_t       state_q;
  seq_state_t       state_d;
  logic [31:0]      cmdBlk_q;
  logic [31:0]      wdata0_q;
  logic [31:0]      wdata1_q;
  logic [15:0]      wdata2_q;
  logic             busy_q;
  logic             done_q;
  logic             failed_q;
  logic [3:0]       step_q;
  logic             ataReq_q;
  logic             ataWrite_q;
  logic [2:0]       ataReg_q;
  logic             ataHob_q;
  logic [7:0]       ataWdata_q;
  logic             dataStart_q;
  logic [BLK_W-1:0] blockSectors_q;
  logic             pready_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;

  // command block fields
  wire logic [7:0] selMask     = cmdBlk_q[MASK_LSB +: 8];
  wire logic [7:0] actSecond   = cmdBlk_q[ACT2_LSB +: 8];
  wire logic [7:0] devHeadData = cmdBlk_q[DEVHEAD_LSB +: 8];
  wire logic       devAfter    = cmdBlk_q[ACT1_LSB + DEV_AFTER_BIT];
  wire logic       readbackOnly = cmdBlk_q[ACT1_LSB + READBACK_BIT];
  wire logic       hobWrite    = actSecond[HOB_WRITE_BIT];
  wire logic [3:0] blkCode     = actSecond[BLK_CODE_LSB +: 4];
  wire logic       blkIllegal  = blkCode > BLK_CODE_MAX;
  wire logic       devSelNeeded = selMask[REG_DEV_HEAD] && !readbackOnly;

  // step table: mask bit, hob flag and readback byte position
  logic [2:0] stepBit;
  logic       stepHob;
  logic [3:0] stepByte;
  always_comb begin
    stepHob = 1'b0;
    case (step_q)
      4'h0: begin stepBit = 3'd0; stepByte = 4'h0; end
      4'h1: begin stepBit = 3'd1; stepByte = 4'h2; end
      4'h2: begin stepBit = 3'd2; stepByte = 4'h3; stepHob = 1'b1; end
      4'h3: begin stepBit = 3'd2; stepByte = 4'h7; end
      4'h4: begin stepBit = 3'd3; stepByte = 4'h4; stepHob = 1'b1; end
      4'h5: begin stepBit = 3'd3; stepByte = 4'h8; end
      4'h6: begin stepBit = 3'd4; stepByte = 4'h5; stepHob = 1'b1; end
      4'h7: begin stepBit = 3'd4; stepByte = 4'h9; end
      4'h8: begin stepBit = 3'd5; stepByte = 4'h6; stepHob = 1'b1; end
      4'h9: begin stepBit = 3'd5; stepByte = 4'hA; end
      4'hA: begin stepBit = 3'd6; stepByte = 4'h1; end
      default: begin stepBit = 3'd7; stepByte = 4'hB; end
    endcase
  end

  // command write data for each step
  logic [7:0] stepWdata;
  always_comb begin
    case (step_q)
      4'h1: stepWdata = wdata0_q[7:0];
      4'h2: stepWdata = wdata0_q[15:8];
      4'h3: stepWdata = wdata1_q[15:8];
      4'h4: stepWdata = wdata0_q[23:16];
      4'h5: stepWdata = wdata1_q[23:16];
      4'h6: stepWdata = wdata0_q[31:24];
      4'h7: stepWdata = wdata1_q[31:24];
      4'h8: stepWdata = wdata1_q[7:0];
      4'h9: stepWdata = wdata2_q[7:0];
      4'hB: stepWdata = wdata2_q[15:8];
      default: stepWdata = 8'h00;
    endcase
  end

  wire logic stepSelected = selMask[stepBit];
  wire logic stepHobOff   = stepHob && !hobWrite;
  wire logic stepDevSel   = stepBit == REG_DEV_HEAD && !readbackOnly;
  wire logic stepCmdInRb  = stepBit == REG_COMMAND && readbackOnly;
  wire logic stepAltInCmd = stepBit == REG_ALT_STATUS && !readbackOnly;
  wire logic stepActive   = stepSelected && !stepHobOff && !stepDevSel && !stepCmdInRb && !stepAltInCmd;
  wire logic inRegs       = state_q == ST_REGS;
  wire logic accDone      = ataReq_q && ataAck;
  wire logic stepAdvance  = inRegs && ((!stepActive && !ataReq_q) || accDone);
  wire logic stepIssue    = inRegs && stepActive && !ataReq_q;
  wire logic lastStep     = step_q == 4'(NUM_STEPS - 1);
  wire logic inSel        = state_q == ST_PRESEL || state_q == ST_POSTSEL;
  wire logic selIssue     = inSel && devSelNeeded && !ataReq_q;

  // readback capture, zero for skipped positions
  wire logic       rbWrEn   = stepAdvance && readbackOnly;
  wire logic [7:0] rbWrData = ataReq_q ? ataRdata : 8'h00;
  wire logic [31:0] rbRdData;

  readback_buffer #(
    .LANES (4),
    .DEPTH (RB_WORDS),
    .AW    (2)
  ) u_readback (
    .clk    (ref_clk),
    .rstN   (rstSync_q),
    .ce     (ce),
    .wrEn   (rbWrEn),
    .wrAddr (stepByte[3:2]),
    .wrLane (stepByte[1:0]),
    .wrData (rbWrData),
    .rdAddr (paddr[3:2]),
    .rdData (rbRdData)
  );

  // apb decode
  wire logic apbAccess = psel && penable && !pready_q;
  wire logic apbDone   = psel && penable && pready_q;
  wire logic apbWr     = apbDone && pwrite;
  wire logic hitCtrl   = paddr == OFF_CTRL;
  wire logic hitCmd    = paddr == OFF_CMD_BLK;
  wire logic hitWd0    = paddr == OFF_WDATA0;
  wire logic hitWd1    = paddr == OFF_WDATA1;
  wire logic hitWd2    = paddr == OFF_WDATA2;
  wire logic hitStat   = paddr == OFF_STATUS;
  wire logic hitBlk    = paddr == OFF_BLKSIZE;
  wire logic hitRb     = paddr[7:4] == OFF_READBACK[7:4] && paddr[3:2] != 2'b11 && paddr[1:0] == 2'b00;
  wire logic hitAny    = hitCtrl | hitCmd | hitWd0 | hitWd1 | hitWd2 | hitStat | hitBlk | hitRb;
  wire logic goCmd     = apbWr && hitCtrl && pwdata[0] && !busy_q;
  wire logic cfgWrOk   = apbWr && !busy_q;
  wire logic doneClr   = apbWr && hitStat && pwdata[ST_DONE];
  wire logic failClr   = apbWr && hitStat && pwdata[ST_FAILED];
  wire logic finishEvt = state_q == ST_FINISH || (state_q == ST_CHECK && blkIllegal);
  wire logic failEvt   = state_q == ST_CHECK && blkIllegal;

  wire logic [31:0] statusWord = {29'h0, failed_q, done_q, busy_q};
  wire logic [31:0] rdMux =
    hitCmd  ? cmdBlk_q :
    hitWd0  ? wdata0_q :
    hitWd1  ? wdata1_q :
    hitWd2  ? {16'h0000, wdata2_q} :
    hitStat ? statusWord :
    hitBlk  ? 32'(blockSectors_q) :
    hitRb   ? rbRdData : 32'h0000_0000;

  // sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (goCmd) begin
          state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (blkIllegal) begin
          state_d = ST_IDLE;
        end else if (readbackOnly || devAfter) begin
          state_d = ST_REGS;
        end else begin
          state_d = ST_PRESEL;
        end
      end
      ST_PRESEL: begin
        if (!devSelNeeded || accDone) begin
          state_d = ST_REGS;
        end
      end
      ST_REGS: begin
        if (stepAdvance && lastStep) begin
          if (readbackOnly) begin
            state_d = ST_FINISH;
          end else if (devAfter) begin
            state_d = ST_POSTSEL;
          end else begin
            state_d = ST_XFER;
          end
        end
      end
      ST_POSTSEL: begin
        if (!devSelNeeded || accDone) begin
          state_d = ST_XFER;
        end
      end
      ST_XFER: begin
        if (dataDone && !dataStart_q) begin
          state_d = ST_FINISH;
        end
      end
      ST_FINISH: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      state_q <= ST_IDLE;
      step_q  <= 4'h0;
    end else if (ce) begin
      state_q <= state_d;
      if (state_q == ST_CHECK) begin
        step_q <= 4'h0;
      end else if (stepAdvance && !lastStep) begin
        step_q <= step_q + 4'h1;
      end
    end
  end

  // ata register port
  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      ataReq_q   <= 1'b0;
      ataWrite_q <= 1'b0;
      ataReg_q   <= REG_ALT_STATUS;
      ataHob_q   <= 1'b0;
      ataWdata_q <= 8'h00;
    end else if (ce) begin
      if (accDone) begin
        ataReq_q <= 1'b0;
      end else if (selIssue) begin
        ataReq_q   <= 1'b1;
        ataWrite_q <= 1'b1;
        ataReg_q   <= REG_DEV_HEAD;
        ataHob_q   <= 1'b0;
        ataWdata_q <= devHeadData;
      end else if (stepIssue) begin
        ataReq_q   <= 1'b1;
        ataWrite_q <= !readbackOnly;
        ataReg_q   <= stepBit;
        ataHob_q   <= stepHob;
        ataWdata_q <= stepWdata;
      end
    end
  end

  // data phase, block size and status
  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      dataStart_q    <= 1'b0;
      blockSectors_q <= '0;
      busy_q         <= 1'b0;
      done_q         <= 1'b0;
      failed_q       <= 1'b0;
    end else if (ce) begin
      dataStart_q <= state_d == ST_XFER && state_q != ST_XFER;
      if (state_q == ST_CHECK && !blkIllegal) begin
        blockSectors_q <= BLK_W'(1) << blkCode;
      end
      busy_q   <= (busy_q | goCmd) & ~finishEvt;
      done_q   <= (done_q & ~doneClr) | finishEvt;
      failed_q <= (failed_q & ~(failClr | goCmd)) | failEvt;
    end
  end

  // configuration registers
  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      cmdBlk_q <= CMD_BLK_RESET;
      wdata0_q <= WDATA_RESET;
      wdata1_q <= WDATA_RESET;
      wdata2_q <= WDATA_RESET[15:0];
    end else if (ce && cfgWrOk) begin
      if (hitCmd) begin
        cmdBlk_q <= pwdata;
      end
      if (hitWd0) begin
        wdata0_q <= pwdata;
      end
      if (hitWd1) begin
        wdata1_q <= pwdata;
      end
      if (hitWd2) begin
        wdata2_q <= pwdata[15:0];
      end
    end
  end

  // apb answer, one wait state
  always_ff @(posedge ref_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q  <= apbAccess;
      pslverr_q <= apbAccess && !hitAny;
      if (apbAccess && !pwrite) begin
        prdata_q <= rdMux;
      end
    end
  end

  assign pready       = pready_q;
  assign prdata       = prdata_q;
  assign pslverr      = pslverr_q;
  assign ataReq       = ataReq_q;
  assign ataWrite     = ataWrite_q;
  assign ataReg       = ataReg_q;
  assign ataHob       = ataHob_q;
  assign ataWdata     = ataWdata_q;
  assign dataStart    = dataStart_q;
  assign blockSectors = blockSectors_q;

endmodule

// >>> tb/taskfile_cb_props.sv
/*
  checker on the decoder's ports: apb answer, ata port handshake, data phase.
  assumes it is bound to the decoder top module below.
*/
`timescale 1ns/1ps
module taskfile_cb_props
  import taskfile_cb_pkg::*;
#(
  parameter int BLK_W = 9
) (
  input wire logic             ref_clk,
  input wire logic             rst_n,
  input wire logic             ce,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic             ataReq,
  input wire logic             ataWrite,
  input wire logic [2:0]       ataReg,
  input wire logic             ataHob,
  input wire logic [7:0]       ataWdata,
  input wire logic             ataAck,
  input wire logic             dataStart,
  input wire logic [BLK_W-1:0] blockSectors
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_APB_WAIT:
    assert property ($rose(penable) && psel && ce |=> pready ##1 !pready) else $error("apb answer mistimed");
  AST_SLVERR_READY:
    assert property (pslverr |-> pready) else $error("error without ready");
  AST_REQ_HOLD:
    assert property (ataReq && !ataAck |=> ataReq && $stable({ataWrite, ataReg, ataHob, ataWdata}))
      else $error("ata request changed before ack");
  AST_REQ_RELEASE:
    assert property (ataReq && ataAck |=> !ataReq) else $error("ata request held after ack");
  AST_HOB_REGS:
    assert property (ataReq && ataHob |-> ataReg inside {[3'h2:3'h5]}) else $error("high-order access off count or lba");
  AST_ALT_READ_ONLY:
    assert property (ataReq && ataReg == REG_ALT_STATUS |-> !ataWrite) else $error("write to alternate status");
  AST_START_QUIET:
    assert property (dataStart |-> !ataReq ##1 (!dataStart && !ataReq) [*4]) else $error("access during data phase");
  AST_BLK_POW2:
    assert property (blockSectors == '0 || $onehot(blockSectors)) else $error("block size not a power of two");

  cover property (ataReq && ataAck && ataHob);
  cover property (dataStart);
  cover property (pready && pslverr);
endmodule

bind taskfile_command_block_decode taskfile_cb_props #(.BLK_W(BLK_W)) i_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .ataReq(ataReq), .ataWrite(ataWrite), .ataReg(ataReg), .ataHob(ataHob),
  .ataWdata(ataWdata), .ataAck(ataAck), .dataStart(dataStart), .blockSectors(blockSectors));

// >>> tb/ata_device_model.sv
/*
  drive model on the ata register port and data phase.
  assumes requests held until ack; answers promptly and slowly by turns.
*/
`timescale 1ns/1ps
module ata_device_model (
  input  wire logic       ref_clk,
  input  wire logic       ataReq,
  input  wire logic [2:0] ataReg,
  input  wire logic       ataHob,
  input  wire logic       dataStart,
  output logic            ataAck,
  output logic      [7:0] ataRdata,
  output logic            dataDone
);
  logic [1:0] waitCnt;
  logic       slow;
  logic [3:0] doneSr;

  initial begin
    ataAck   = 1'b0;
    ataRdata = 8'h00;
    dataDone = 1'b0;
    waitCnt  = 2'h0;
    slow     = 1'b0;
    doneSr   = 4'h0;
  end

  always @(posedge ref_clk) begin
    ataAck   <= 1'b0;
    ataRdata <= ~ataRdata; // released bus does not hold its value
    if (ataReq && !ataAck) begin
      if (waitCnt == 2'h0) begin
        ataAck   <= 1'b1;
        ataRdata <= {3'b101, ataHob, 1'b0, ataReg};
        slow     <= ~slow;
        waitCnt  <= slow ? 2'h0 : 2'h3;
      end else begin
        waitCnt <= waitCnt - 2'h1;
      end
    end
    doneSr   <= {doneSr[2:0], dataStart};
    dataDone <= doneSr[3];
  end
endmodule

// >>> tb/taskfile_command_block_decode_tb_top.sv
/*
  testbench: apb tasks drive command blocks, ata port accesses are logged.
  assumes the drive model answers reads with a code of register and hob.
*/
`timescale 1ns/1ps
module taskfile_command_block_decode_tb_top;
  import taskfile_cb_pkg::*;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, ataReq, ataWrite, ataHob, ataAck;
  logic        dataStart, dataDone, err;
  logic [7:0]  paddr, ataWdata, ataRdata;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  ataReg;
  logic [8:0]  blockSectors;
  logic [12:0] logQ [$];
  int          errorCnt = 0;
  int          checked  = 0;
  int          dsCnt    = 0;

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  taskfile_command_block_decode #(.BLK_W(9)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ataReq(ataReq), .ataWrite(ataWrite), .ataReg(ataReg), .ataHob(ataHob), .ataWdata(ataWdata),
    .ataAck(ataAck), .ataRdata(ataRdata), .dataStart(dataStart), .dataDone(dataDone),
    .blockSectors(blockSectors));
  ata_device_model i_ata (.ref_clk(ref_clk), .ataReq(ataReq), .ataReg(ataReg), .ataHob(ataHob),
    .dataStart(dataStart), .ataAck(ataAck), .ataRdata(ataRdata), .dataDone(dataDone));

  always @(posedge ref_clk) begin
    if (ataReq && ataAck) logQ.push_back({ataWrite, ataHob, ataReg, ataWrite ? ataWdata : 8'h00});
    if (dataStart) dsCnt++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk iff pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  function automatic logic [31:0] cmdw(input logic [7:0] m, input logic aft, input logic rb,
                                       input logic [3:0] code, input logic hob);
    return {8'hE0, code, 3'b000, hob, 6'h00, aft, rb, m};
  endfunction

  function automatic logic [12:0] w(input logic [2:0] r, input logic h, input logic [7:0] d);
    return {1'b1, h, r, d};
  endfunction

  task automatic run(input logic [31:0] cmd, input logic [31:0] expSt);
    int n;
    n = 0;
    apb(1'b1, OFF_CMD_BLK, cmd);
    logQ.delete();
    dsCnt = 0;
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    do begin
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      n++;
    end while (rd[ST_DONE] !== 1'b1 && n < 100);
    check(rd & 32'h0000_0007, expSt);
    apb(1'b1, OFF_STATUS, 32'h0000_0006);
  endtask

  task automatic checkLog(input logic [12:0] exp [$]);
    check(32'(logQ.size()), 32'(exp.size()));
    foreach (exp[i]) check(32'(i < logQ.size() ? logQ[i] : 13'h1FFF), 32'(exp[i]));
  endtask

  task automatic rbCheck(input logic [31:0] e [3]);
    foreach (e[i]) begin
      apb(1'b0, OFF_READBACK + 8'(4 * i), 32'h0000_0000);
      check(rd, e[i]);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #200us;
    errorCnt++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    apb(1'b1, OFF_WDATA0, 32'h9988_7766);
    apb(1'b1, OFF_WDATA1, 32'hDDCC_BBAA);
    apb(1'b1, OFF_WDATA2, 32'h0000_FFEE);
    run(cmdw(8'hFF, 1'b0, 1'b1, 4'h0, 1'b1), 32'h0000_0002);
    rbCheck('{32'hB2A1_A6A0, 32'hA2B5_B4B3, 32'h00A5_A4A3});
    check(32'(dsCnt), 32'h0000_0000);
    $display("test readback full done");
    run(cmdw(8'h05, 1'b0, 1'b1, 4'h0, 1'b0), 32'h0000_0002);
    rbCheck('{32'h0000_00A0, 32'hA200_0000, 32'h0000_0000});
    $display("test readback sparse done");
    run(cmdw(8'hFF, 1'b0, 1'b0, 4'h8, 1'b1), 32'h0000_0002);
    checkLog('{w(6, 0, 8'hE0), w(1, 0, 8'h66), w(2, 1, 8'h77), w(2, 0, 8'hBB), w(3, 1, 8'h88),
      w(3, 0, 8'hCC), w(4, 1, 8'h99), w(4, 0, 8'hDD), w(5, 1, 8'hAA), w(5, 0, 8'hEE), w(7, 0, 8'hFF)});
    check(32'(dsCnt), 32'h0000_0001);
    apb(1'b0, OFF_BLKSIZE, 32'h0000_0000);
    check(rd, 32'h0000_0100);
    check(32'(blockSectors), 32'h0000_0100);
    $display("test command select first done");
    run(cmdw(8'hC4, 1'b1, 1'b0, 4'h0, 1'b0), 32'h0000_0002);
    checkLog('{w(2, 0, 8'hBB), w(7, 0, 8'hFF), w(6, 0, 8'hE0)});
    apb(1'b0, OFF_BLKSIZE, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    $display("test command select after done");
    for (int c = 9; c < 16; c += 6) begin
      run(cmdw(8'hFE, 1'b0, 1'b0, 4'(c), 1'b1), 32'h0000_0006);
      check(32'(logQ.size() + dsCnt), 32'h0000_0000);
    end
    apb(1'b0, OFF_BLKSIZE, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    $display("test illegal block size done");
    apb(1'b0, 8'h1C, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    $display("test unmapped address done");
    end_of_test();
  end
endmodule
